//--- src/psm_consts.vh
`ifndef PSM_CONSTS_VH
`define PSM_CONSTS_VH
// Selector positions.
`define PSM_SEL_MID      2'h0
`define PSM_SEL_TOP      2'h1
`define PSM_SEL_LOW      2'h2
// Lamp colour codes: bit 0 red, bit 1 green, both for orange.
`define PSM_LAMP_OFF     2'h0
`define PSM_LAMP_RED     2'h1
`define PSM_LAMP_GREEN   2'h2
`define PSM_LAMP_ORANGE  2'h3
// Register offsets.
`define PSM_REG_CTRL     4'h0
`define PSM_REG_STATUS   4'h1
`define PSM_REG_USER     4'h2
`define PSM_REG_CYCLE    4'h3
`define PSM_REG_ADDR_LO  4'h4
`define PSM_REG_ADDR_HI  4'h5
// Control register bits.
`define PSM_CTRL_START   0
`define PSM_CTRL_STOP    1
`define PSM_CTRL_PROGEND 2
`define PSM_CTRL_HKEND   3
`define PSM_CTRL_INITOK  4
`define PSM_CTRL_INITERR 5
// Blink half period in cycles.
`define PSM_BLINK_TIME_MS 250
`define PSM_CLK_MHZ       125
`define PSM_BLINK_CYCLES  (`PSM_BLINK_TIME_MS * 1000 * `PSM_CLK_MHZ)
// Station address default, arbitrary value.
`define PSM_STATION_ADDR  48'h02_00_00_00_00_01
`endif

//--- src/psm_scan_sequencer.v
// Operation
// [RULE_01] Middle-to-top selector move requests run
// [RULE_02] Top-to-middle selector move requests stop
// [RULE_03] Lowest position starts the loader
// [RULE_04] Push causes hardware reset clearing outputs
// [RULE_05] Push reset works in any mode
// [RULE_06] Run/stop changes apply at cycle end
// [RULE_07] Tool start/stop honoured in any position
// [RULE_08] Outputs hold their value when stopped
// [RULE_09] Flag marks final cycle before stop
// [RULE_10] Start-up follows power-on and reset
// [RULE_11] Copy program, then detect modules
// [RULE_12] Init clears variables, flags keep status
// [RULE_13] Fault lamp blinks red during init
// [RULE_14] Clean start-up gives run, steady green
// [RULE_15] Scanning starts on top position or start; code also starts it after init with selector in middle
// [RULE_16] Scan: read, execute, write, housekeeping, repeat
// [RULE_17] I/O frozen while program executes
// [RULE_18] Cycle time counts execution start to start
// [RULE_19] Link and traffic lamps show network
// [RULE_20] Module and network lamps red/green
// [RULE_21] User lamp driven by application
// [RULE_22] Fixed 48-bit station address held
// [RULE_23] Reset aborts scan and restarts start-up
//
// Decided for this implementation: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "psm_consts.vh"
module psm_scan_sequencer #(
   parameter [31:0] BLINK_CYCLES = `PSM_BLINK_CYCLES,
   parameter [47:0] STATION_ADDR = `PSM_STATION_ADDR
) (
   input  wire        clk_sys,
   input  wire        rst_n,
   input  wire [1:0]  selPos,
   input  wire        selPush,
   input  wire        linkUp,
   input  wire        trafficActive,
   input  wire        netFault,
   input  wire        copyDone,
   input  wire        detectDone,
   input  wire [3:0]  regAddr,
   input  wire [31:0] regWrData,
   input  wire        regWr,
   input  wire        regRd,
   output reg  [31:0] regRdData,
   output reg         hwReset,
   output reg         loaderStart,
   output reg         copyReq,
   output reg         detectReq,
   output reg         varInit,
   output reg         inputLatch,
   output reg         programRun,
   output reg         outputWrite,
   output reg         housekeeping,
   output reg         runMode,
   output reg         last_cycle_before_halt,
   output reg  [1:0]  module_state_lamp,
   output reg  [1:0]  network_state_lamp,
   output reg  [1:0]  user_lamp,
   output reg  [1:0]  nodeFaultLamp,
   output reg         linkLamp,
   output reg         trafficLamp,
   output reg  [47:0] hardware_station_address
);

   localparam [3:0] ST_COPY   = 4'h0;
   localparam [3:0] ST_DETECT = 4'h1;
   localparam [3:0] ST_INIT   = 4'h2;
   localparam [3:0] ST_STOP   = 4'h3;
   localparam [3:0] ST_READ   = 4'h4;
   localparam [3:0] ST_EXEC   = 4'h5;
   localparam [3:0] ST_WRITE  = 4'h6;
   localparam [3:0] ST_HOUSE  = 4'h7;
   localparam [3:0] ST_LOADER = 4'h8;
   localparam [3:0] ST_FAULT  = 4'h9;

   reg [3:0]  state;
   reg [1:0]  selPrev;
   reg        pushPrev;
   reg        runReq;
   reg        startPend;
   reg        stopPend;
   reg        hkEndSeen;
   reg [31:0] cycleCount;
   reg [31:0] cycleTime;
   reg [31:0] blinkCount;
   reg        blinkPhase;
   reg        initErr;

   wire pushEdge = selPush & ~pushPrev;
   wire selUp    = (selPrev == `PSM_SEL_MID) && (selPos == `PSM_SEL_TOP);
   wire selDown  = (selPrev == `PSM_SEL_TOP) && (selPos == `PSM_SEL_MID);
   wire swStart  = regWr && (regAddr == `PSM_REG_CTRL) && regWrData[`PSM_CTRL_START];
   wire swStop   = regWr && (regAddr == `PSM_REG_CTRL) && regWrData[`PSM_CTRL_STOP];
   wire progEnd  = regWr && (regAddr == `PSM_REG_CTRL) && regWrData[`PSM_CTRL_PROGEND];
   wire hkEnd    = regWr && (regAddr == `PSM_REG_CTRL) && regWrData[`PSM_CTRL_HKEND];
   wire initOk   = regWr && (regAddr == `PSM_REG_CTRL) && regWrData[`PSM_CTRL_INITOK];
   wire initBad  = regWr && (regAddr == `PSM_REG_CTRL) && regWrData[`PSM_CTRL_INITERR];

   // Decides whether the scan at its end should carry on running.
   function keepRunning;
      input curRun;
      input start;
      input stop;
      begin
         if (stop)
            keepRunning = 1'b0;
         else if (start)
            keepRunning = 1'b1;
         else
            keepRunning = curRun;
      end
   endfunction

   always @(posedge clk_sys) begin
      if (!rst_n) begin
         // Loading the live position avoids a false selector move just after reset.
         selPrev  <= selPos;
         pushPrev <= 1'b0;
      end else begin
         selPrev  <= selPos;
         pushPrev <= selPush;
      end
   end

   // The pending request bits are latched so a request made mid-scan waits for cycle end.
   always @(posedge clk_sys) begin
      if (!rst_n || pushEdge) begin
         startPend <= 1'b0;
         stopPend  <= 1'b0;
      end else if (state == ST_HOUSE && hkEndSeen) begin
         // [RULE_06] consume at end
         startPend <= swStart | selUp;
         // A stop raised after the final-cycle flag was due waits one more scan.
         stopPend  <= swStop | selDown | (stopPend & ~last_cycle_before_halt);
      end else begin
         // [RULE_01] [RULE_02] selector requests
         // [RULE_07] tool commands anywhere
         if (swStart || selUp) begin
            startPend <= 1'b1;
            stopPend  <= 1'b0;
         end
         if (swStop || selDown) begin
            stopPend  <= 1'b1;
            startPend <= 1'b0;
         end
      end
   end

   always @(posedge clk_sys) begin
      if (!rst_n) begin
         state        <= ST_COPY;
         hwReset      <= 1'b0;
         loaderStart  <= 1'b0;
         copyReq      <= 1'b0;
         detectReq    <= 1'b0;
         varInit      <= 1'b0;
         inputLatch   <= 1'b0;
         programRun   <= 1'b0;
         outputWrite  <= 1'b0;
         housekeeping <= 1'b0;
         runMode      <= 1'b0;
         runReq       <= 1'b0;
         hkEndSeen    <= 1'b0;
         initErr      <= 1'b0;
         last_cycle_before_halt <= 1'b0;
      end else if (pushEdge) begin
         // [RULE_04] [RULE_05] push reset
         // [RULE_23] abort and restart
         state        <= ST_COPY;
         hwReset      <= 1'b1;
         loaderStart  <= 1'b0;
         copyReq      <= 1'b0;
         detectReq    <= 1'b0;
         varInit      <= 1'b0;
         inputLatch   <= 1'b0;
         programRun   <= 1'b0;
         outputWrite  <= 1'b0;
         housekeeping <= 1'b0;
         runMode      <= 1'b0;
         runReq       <= 1'b0;
         hkEndSeen    <= 1'b0;
         initErr      <= 1'b0;
         last_cycle_before_halt <= 1'b0;
      end else begin
         hwReset     <= 1'b0;
         inputLatch  <= 1'b0;
         outputWrite <= 1'b0;
         varInit     <= 1'b0;
         case (state)
            // [RULE_10] [RULE_11] copy then detect
            ST_COPY: begin
               copyReq <= 1'b1;
               if (copyDone) begin
                  copyReq   <= 1'b0;
                  detectReq <= 1'b1;
                  state     <= ST_DETECT;
               end
            end
            ST_DETECT: begin
               if (detectDone) begin
                  detectReq <= 1'b0;
                  // [RULE_12] init variables
                  varInit   <= 1'b1;
                  state     <= ST_INIT;
               end
            end
            ST_INIT: begin
               if (initBad) begin
                  initErr <= 1'b1;
                  state   <= ST_FAULT;
               end else if (initOk) begin
                  // [RULE_03] loader position
                  if (selPos == `PSM_SEL_LOW) begin
                     loaderStart <= 1'b1;
                     state       <= ST_LOADER;
                  end else begin
                     // [RULE_14] [RULE_15] enter run
                     runMode    <= 1'b1;
                     runReq     <= 1'b1;
                     inputLatch <= 1'b1;
                     state      <= ST_READ;
                  end
               end
            end
            ST_STOP: begin
               // [RULE_08] outputs held
               if (startPend) begin
                  runMode    <= 1'b1;
                  runReq     <= 1'b1;
                  inputLatch <= 1'b1;
                  state      <= ST_READ;
               end
            end
            // [RULE_16] scan sequence
            ST_READ: begin
               programRun <= 1'b1;
               state      <= ST_EXEC;
            end
            ST_EXEC: begin
               // [RULE_09] final cycle flag
               last_cycle_before_halt <= stopPend | swStop | selDown;
               if (progEnd) begin
                  // [RULE_17] exchange after program
                  programRun  <= 1'b0;
                  outputWrite <= 1'b1;
                  state       <= ST_WRITE;
               end
            end
            ST_WRITE: begin
               housekeeping <= 1'b1;
               hkEndSeen    <= 1'b0;
               state        <= ST_HOUSE;
            end
            ST_HOUSE: begin
               if (hkEnd)
                  hkEndSeen <= 1'b1;
               if (hkEndSeen) begin
                  housekeeping <= 1'b0;
                  hkEndSeen    <= 1'b0;
                  last_cycle_before_halt <= 1'b0;
                  if (keepRunning(runReq, startPend, stopPend & last_cycle_before_halt)) begin
                     inputLatch <= 1'b1;
                     state      <= ST_READ;
                  end else begin
                     runMode <= 1'b0;
                     runReq  <= 1'b0;
                     state   <= ST_STOP;
                  end
               end
            end
            ST_LOADER: begin
               loaderStart <= 1'b1;
            end
            ST_FAULT: begin
               runMode <= 1'b0;
            end
            default: begin
               state <= ST_COPY;
            end
         endcase
      end
   end

   // [RULE_18] cycle time measure
   always @(posedge clk_sys) begin
      if (!rst_n || pushEdge) begin
         cycleCount <= 32'h0000_0000;
         cycleTime  <= 32'h0000_0000;
      end else if (state == ST_READ) begin
         cycleTime  <= cycleCount;
         cycleCount <= 32'h0000_0001;
      end else if (cycleCount != 32'hffff_ffff) begin
         cycleCount <= cycleCount + 32'h0000_0001;
      end
   end

   always @(posedge clk_sys) begin
      if (!rst_n || blinkCount >= BLINK_CYCLES - 32'h0000_0001) begin
         blinkCount <= 32'h0000_0000;
         blinkPhase <= rst_n ? ~blinkPhase : 1'b0;
      end else begin
         blinkCount <= blinkCount + 32'h0000_0001;
      end
   end

   always @(posedge clk_sys) begin
      if (!rst_n) begin
         user_lamp          <= `PSM_LAMP_OFF;
         nodeFaultLamp      <= `PSM_LAMP_OFF;
         module_state_lamp  <= `PSM_LAMP_OFF;
         network_state_lamp <= `PSM_LAMP_OFF;
         linkLamp           <= 1'b0;
         trafficLamp        <= 1'b0;
         hardware_station_address <= 48'h0000_0000_0000;
      end else begin
         // [RULE_22] fixed address
         hardware_station_address <= STATION_ADDR;
         // [RULE_21] user lamp
         if (pushEdge)
            user_lamp <= `PSM_LAMP_OFF;
         else if (regWr && regAddr == `PSM_REG_USER)
            user_lamp <= regWrData[1:0];
         // [RULE_13] [RULE_14] fault lamp
         if (state <= ST_INIT)
            nodeFaultLamp <= blinkPhase ? `PSM_LAMP_RED : `PSM_LAMP_OFF;
         else if (state == ST_FAULT)
            nodeFaultLamp <= `PSM_LAMP_RED;
         else
            nodeFaultLamp <= `PSM_LAMP_GREEN;
         // [RULE_20] module and network lamps
         module_state_lamp  <= initErr ? `PSM_LAMP_RED : `PSM_LAMP_GREEN;
         network_state_lamp <= netFault ? `PSM_LAMP_RED : `PSM_LAMP_GREEN;
         // [RULE_19] link and traffic
         linkLamp    <= linkUp;
         trafficLamp <= trafficActive;
      end
   end

   always @(posedge clk_sys) begin
      if (!rst_n) begin
         regRdData <= 32'h0000_0000;
      end else if (regRd) begin
         if (regAddr == `PSM_REG_STATUS)
            regRdData <= {22'h00_0000, initErr, last_cycle_before_halt, stopPend,
                          startPend, runMode, 1'b0, state};
         else if (regAddr == `PSM_REG_USER)
            regRdData <= {30'h0000_0000, user_lamp};
         else if (regAddr == `PSM_REG_CYCLE)
            regRdData <= cycleTime;
         else if (regAddr == `PSM_REG_ADDR_LO)
            regRdData <= hardware_station_address[31:0];
         else if (regAddr == `PSM_REG_ADDR_HI)
            regRdData <= {16'h0000, hardware_station_address[47:32]};
         else
            regRdData <= 32'h0000_0000;
      end else begin
         regRdData <= 32'h0000_0000;
      end
   end

endmodule // psm_scan_sequencer
`default_nettype wire

//--- testbench/plc_scan_mode_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "psm_consts.vh"
module plc_scan_mode_sequencer_tb;
   logic        clk_sys = 1'b0, rst_n = 1'b0, selPush = 1'b0, slow = 1'b1;
   logic [1:0]  selPos = `PSM_SEL_TOP;
   logic        linkUp = 1'b0, trafficActive = 1'b0, netFault = 1'b0, copyDone, detectDone;
   logic [3:0]  regAddr = 4'h0;
   logic [31:0] regWrData = 32'h0, regRdData, rdVal;
   logic        regWr = 1'b0, regRd = 1'b0, hwReset, loaderStart, copyReq, detectReq, varInit;
   logic        inputLatch, programRun, outputWrite, housekeeping, runMode, linkLamp, trafficLamp;
   logic        last_cycle_before_halt;
   logic [1:0]  module_state_lamp, network_state_lamp, user_lamp, nodeFaultLamp;
   logic [47:0] hardware_station_address;
   int          miscompares = 0, comparisons = 0;
   psm_scan_sequencer #(.BLINK_CYCLES(32'h4), .STATION_ADDR(48'h0a0b0c0d0e0f)) uut (.*);
   psm_io_model io (.clk_sys(clk_sys), .slow(slow), .copyReq(copyReq), .detectReq(detectReq),
      .copyDone(copyDone), .detectDone(detectDone));
   initial forever #4 clk_sys = ~clk_sys;
   // Cycles between program starts, measured independently of the block.
   int          runGap = 0, lastGap = 0;
   logic        runSeen = 1'b0;
   always @(posedge clk_sys) begin
      runSeen <= programRun;
      runGap <= (programRun && !runSeen) ? 1 : runGap + 1;
      if (programRun && !runSeen)
         lastGap <= runGap;
   end
   task give_verdict;
      $display("miscompares=%0d comparisons=%0d", miscompares, comparisons);
      if (miscompares == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task chk(input logic [47:0] got, input logic [47:0] exp);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Sampling at the falling edge also catches one-cycle pulses.
   task automatic waitOn(ref logic s);
      int n;
      for (n = 0; n < 300 && s !== 1'b1; n++)
         @(negedge clk_sys);
      if (s !== 1'b1) begin
         miscompares++;
         give_verdict();
      end
   endtask
   task wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      regAddr <= a;
      regWrData <= d;
      regWr <= 1'b1;
      @(posedge clk_sys);
      regWr <= 1'b0;
   endtask
   task rd(input logic [3:0] a);
      @(posedge clk_sys);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk_sys);
      regRd <= 1'b0;
      @(negedge clk_sys);
      rdVal = regRdData;
   endtask
   task startUp(input logic [1:0] sel, input logic sl);
      int red;
      red = 0;
      @(posedge clk_sys);
      rst_n <= 1'b0;
      selPos <= sel;
      slow <= sl;
      repeat (20) @(posedge clk_sys);
      rst_n <= 1'b1;
      waitOn(varInit);
      repeat (8) begin
         @(negedge clk_sys);
         red += (nodeFaultLamp === `PSM_LAMP_RED);
      end
      chk(red > 0 && red < 8, 1'b1);
      wr(`PSM_REG_CTRL, 32'h1 << `PSM_CTRL_INITOK);
      repeat (3) @(negedge clk_sys);
      if (sel == `PSM_SEL_LOW)
         chk(loaderStart, 1'b1);
      else
         chk({runMode, nodeFaultLamp}, {1'b1, `PSM_LAMP_GREEN});
   endtask
   task scan(input logic toolStop, input logic expRun);
      waitOn(programRun);
      if (toolStop) begin
         rd(`PSM_REG_CYCLE);
         chk(rdVal, lastGap);
         wr(`PSM_REG_CTRL, 32'h1 << `PSM_CTRL_STOP);
      end
      repeat (2) @(negedge clk_sys);
      chk(runMode, 1'b1);
      chk(last_cycle_before_halt, !expRun);
      wr(`PSM_REG_CTRL, 32'h1 << `PSM_CTRL_PROGEND);
      waitOn(outputWrite);
      @(negedge clk_sys);
      chk(housekeeping, 1'b1);
      wr(`PSM_REG_CTRL, 32'h1 << `PSM_CTRL_HKEND);
      repeat (4) @(negedge clk_sys);
      chk(runMode, expRun);
   endtask
   task regs;
      rd(`PSM_REG_ADDR_LO);
      chk(rdVal, 48'h0c0d0e0f);
      rd(`PSM_REG_ADDR_HI);
      chk(rdVal, 48'h0a0b);
      rd(4'hf);
      chk(rdVal, 48'h0);
      chk(hardware_station_address, 48'h0a0b0c0d0e0f);
      rd(`PSM_REG_STATUS);
      chk(rdVal[9:5], 5'h01);
      chk(module_state_lamp, `PSM_LAMP_GREEN);
      wr(`PSM_REG_USER, {30'h0, `PSM_LAMP_ORANGE});
      @(posedge clk_sys);
      linkUp <= 1'b1;
      trafficActive <= 1'b1;
      netFault <= 1'b1;
      repeat (3) @(negedge clk_sys);
      chk(user_lamp, `PSM_LAMP_ORANGE);
      chk({linkLamp, trafficLamp}, 2'h3);
      chk(network_state_lamp, `PSM_LAMP_RED);
   endtask
   initial begin
      startUp(`PSM_SEL_TOP, 1'b1);
      regs;
      scan(1'b0, 1'b1);
      scan(1'b1, 1'b0);
      @(posedge clk_sys);
      selPos <= `PSM_SEL_MID;
      repeat (3) @(posedge clk_sys);
      selPos <= `PSM_SEL_TOP;
      waitOn(programRun);
      @(posedge clk_sys);
      selPos <= `PSM_SEL_MID;
      scan(1'b0, 1'b0);
      wr(`PSM_REG_CTRL, 32'h1 << `PSM_CTRL_START);
      waitOn(programRun);
      @(posedge clk_sys);
      selPush <= 1'b1;
      waitOn(copyReq);
      chk({programRun, runMode, outputWrite}, 3'h0);
      @(posedge clk_sys);
      selPush <= 1'b0;
      startUp(`PSM_SEL_LOW, 1'b0);
      @(posedge clk_sys);
      selPush <= 1'b1;
      @(posedge clk_sys);
      selPush <= 1'b0;
      waitOn(varInit);
      wr(`PSM_REG_CTRL, 32'h1 << `PSM_CTRL_INITERR);
      repeat (3) @(negedge clk_sys);
      chk({module_state_lamp, nodeFaultLamp}, {`PSM_LAMP_RED, `PSM_LAMP_RED});
      give_verdict;
   end
endmodule // plc_scan_mode_sequencer_tb
`default_nettype wire

//--- testbench/psm_io_model.sv
`timescale 1ns/1ps
`default_nettype none
module psm_io_model (
   input  wire logic clk_sys,
   input  wire logic slow,
   input  wire logic copyReq,
   input  wire logic detectReq,
   output var logic  copyDone,
   output var logic  detectDone
);
   logic [3:0] waitCnt = 4'h0;
   initial copyDone = 1'b0;
   initial detectDone = 1'b0;
   // copy then detect
   // The slow answer keeps the detect phase long enough to watch the lamp blink.
   always @(posedge clk_sys) begin
      waitCnt <= (copyReq || detectReq) && !copyDone && !detectDone ? waitCnt + 4'h1 : 4'h0;
      copyDone <= copyReq && waitCnt == (slow ? 4'h9 : 4'h1);
      detectDone <= detectReq && waitCnt == (slow ? 4'h9 : 4'h1);
   end
endmodule // psm_io_model
`default_nettype wire

//--- testbench/psm_sequencer_checker_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "psm_consts.vh"
module psm_sequencer_checker (
   input wire        clk_sys,
   input wire        rst_n,
   input wire        selPush,
   input wire [3:0]  regAddr,
   input wire [31:0] regWrData,
   input wire        regWr,
   input wire        hwReset,
   input wire        copyReq,
   input wire        detectReq,
   input wire        inputLatch,
   input wire        programRun,
   input wire        outputWrite,
   input wire        runMode,
   input wire [1:0]  nodeFaultLamp
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   sequence s_progEnd;
      regWr && regAddr == `PSM_REG_CTRL && regWrData[`PSM_CTRL_PROGEND] && programRun;
   endsequence
   sequence s_writeOut;
      ##[1:3] outputWrite;
   endsequence
   property p_pushPulse;
      $rose(selPush) |=> hwReset ##1 !hwReset;
   endproperty
   a_pushPulse: assert property (p_pushPulse) else $error("push gave no single reset pulse");
   property p_pushRestart;
      hwReset |-> ##[1:3] copyReq;
   endproperty
   a_pushRestart: assert property (p_pushRestart) else $error("start-up not restarted");
   property p_copyFirst;
      $rose(detectReq) |-> $past(copyReq);
   endproperty
   a_copyFirst: assert property (p_copyFirst) else $error("detect began before copy");
   property p_frozen;
      programRun |-> !inputLatch && !outputWrite;
   endproperty
   a_frozen: assert property (p_frozen) else $error("I/O exchanged during execution");
   property p_outWrite;
      s_progEnd |-> s_writeOut;
   endproperty
   a_outWrite: assert property (p_outWrite) else $error("no output write after program");
   property p_runGreen;
      programRun |-> nodeFaultLamp == `PSM_LAMP_GREEN;
   endproperty
   a_runGreen: assert property (p_runGreen) else $error("fault lamp not green in run");
   property p_initLamp;
      detectReq |-> !nodeFaultLamp[1];
   endproperty
   a_initLamp: assert property (p_initLamp) else $error("fault lamp green during init");
   property p_stopHolds;
      outputWrite |-> runMode;
   endproperty
   a_stopHolds: assert property (p_stopHolds) else $error("outputs written while stopped");
endmodule // psm_sequencer_checker
bind psm_scan_sequencer psm_sequencer_checker chk (.*);
`default_nettype wire
